// ---- src/ump_uart_dev.sv ----
`timescale 1ns/1ns
module ump_uart_dev (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_rd,
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    output logic      [7:0] cpu_rdata,
    input  wire logic       int_enable,
    input  wire logic [7:0] timer_reload_byte,
    input  wire logic       timer_tick,
    output logic            irq,
    ump_link_if.dev         link
);
    import ump_pkg::*;

    typedef enum logic [2:0] {
        UMP_TX_IDLE  = 3'b000,
        UMP_TX_LOAD  = 3'b001,
        UMP_TX_START = 3'b011,
        UMP_TX_DATA  = 3'b010,
        UMP_TX_NINTH = 3'b110,
        UMP_TX_STOP  = 3'b111
    } ump_tx_t;

    typedef enum logic [2:0] {
        UMP_RX_IDLE  = 3'b000,
        UMP_RX_START = 3'b001,
        UMP_RX_DATA  = 3'b011,
        UMP_RX_NINTH = 3'b010,
        UMP_RX_STOP  = 3'b110
    } ump_rx_t;

    ump_tx_t    tx_state_q;
    ump_rx_t    rx_state_q;
    logic       mode_q;
    logic       afe_q;
    logic       ren_q;
    logic       tb8_q;
    logic       rb8_q;
    logic       ti_q;
    logic       ri_q;
    logic [7:0] tx_tmr_q;
    logic [7:0] rx_tmr_q;
    logic       tx_half_q;
    logic       rx_half_q;
    logic [7:0] tx_shift_q;
    logic       tx_ninth_q;
    logic       tx_nine_q;
    logic [2:0] tx_cnt_q;
    logic       tx_line_q;
    logic [7:0] rx_shift_q;
    logic [2:0] rx_cnt_q;
    logic       rx_nine_q;
    logic       rx_ninth_q;
    logic       rx_prev_q;
    logic [7:0] rx_buf_q;
    logic       rxd;
    logic       ctrl_wr;
    logic       data_wr;
    logic       tx_ovf;
    logic       rx_ovf;
    logic       tx_baud;
    logic       rx_start;
    logic       rx_sample;
    logic       rx_accept;
    logic       rx_load;
    logic       rx_ninth_val;
    logic       tx_done_set;

    assign rxd     = link.serial_receive_line;
    assign ctrl_wr = cpu_wr & (cpu_addr == UMP_CTRL_ADDR);
    assign data_wr = cpu_wr & (cpu_addr == UMP_DATA_ADDR);
    assign link.serial_transmit_line = tx_line_q;

    // shared 8-bit auto-reload timer, one copy per direction
    assign tx_ovf  = timer_tick & (tx_tmr_q == UMP_TMR_TOP);
    assign rx_ovf  = timer_tick & (rx_tmr_q == UMP_TMR_TOP);
    assign tx_baud = tx_ovf & tx_half_q;            // see [R01] see [R02]
    // first rx overflow after the forced reload falls mid bit
    assign rx_sample = rx_ovf & ~rx_half_q;         // see [R22]
    assign rx_start  = ren_q & (rx_state_q == UMP_RX_IDLE) & rx_prev_q & ~rxd; // see [R02] see [R07]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_tmr_q  <= 8'h00;
            tx_half_q <= 1'b0;
        end else if (tx_ovf) begin
            tx_tmr_q  <= timer_reload_byte;         // see [R01]
            tx_half_q <= ~tx_half_q;                // see [R02]
        end else if (timer_tick) begin
            tx_tmr_q  <= tx_tmr_q + 8'h01;
        end
    end

    // rx copy restarts on a start edge, independent of the tx copy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_tmr_q  <= 8'h00;
            rx_half_q <= 1'b0;
        end else if (rx_start) begin
            rx_tmr_q  <= timer_reload_byte;         // see [R02]
            rx_half_q <= 1'b0;
        end else if (rx_ovf) begin
            rx_tmr_q  <= timer_reload_byte;
            rx_half_q <= ~rx_half_q;
        end else if (timer_tick) begin
            rx_tmr_q  <= rx_tmr_q + 8'h01;
        end
    end

    // transmitter; a write while busy is dropped to protect the frame
    assign tx_done_set = tx_baud & (((tx_state_q == UMP_TX_DATA) & (tx_cnt_q == UMP_LAST_DATA)
                          & ~tx_nine_q) | (tx_state_q == UMP_TX_NINTH)); // see [R06]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state_q <= UMP_TX_IDLE;
            tx_shift_q <= 8'h00;
            tx_ninth_q <= 1'b0;
            tx_nine_q  <= 1'b0;
            tx_cnt_q   <= 3'h0;
            tx_line_q  <= 1'b1;
        end else begin
            unique case (tx_state_q)
                UMP_TX_IDLE: begin
                    tx_line_q <= 1'b1;                  // see [R22]
                    if (data_wr) begin
                        tx_shift_q <= cpu_wdata;        // see [R05] see [R21]
                        tx_nine_q  <= mode_q;           // see [R03]
                        tx_ninth_q <= mode_q & tb8_q;   // see [R19]
                        tx_state_q <= UMP_TX_LOAD;
                    end
                end
                UMP_TX_LOAD: if (tx_baud) begin
                    tx_line_q  <= 1'b0;
                    tx_state_q <= UMP_TX_START;
                end
                UMP_TX_START: if (tx_baud) begin
                    tx_line_q  <= tx_shift_q[0];        // see [R04]
                    tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                    tx_cnt_q   <= 3'h0;
                    tx_state_q <= UMP_TX_DATA;
                end
                UMP_TX_DATA: if (tx_baud) begin
                    if (tx_cnt_q != UMP_LAST_DATA) begin
                        tx_line_q  <= tx_shift_q[0];
                        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                        tx_cnt_q   <= tx_cnt_q + 3'h1;
                    end else if (tx_nine_q) begin
                        tx_line_q  <= tx_ninth_q;       // see [R11]
                        tx_state_q <= UMP_TX_NINTH;
                    end else begin
                        tx_line_q  <= 1'b1;
                        tx_state_q <= UMP_TX_STOP;
                    end
                end
                UMP_TX_NINTH: if (tx_baud) begin
                    tx_line_q  <= 1'b1;
                    tx_state_q <= UMP_TX_STOP;
                end
                UMP_TX_STOP: if (tx_baud) begin
                    tx_state_q <= UMP_TX_IDLE;
                end
                default: tx_state_q <= UMP_TX_IDLE;
            endcase
        end
    end

    // acceptance: flag must be clear, filter checks stop or ninth bit
    assign rx_ninth_val = rx_nine_q ? rx_ninth_q : rxd;               // see [R08] see [R12]
    assign rx_accept    = ~ri_q & (~afe_q | rx_ninth_val);            // see [R09] see [R10] see [R13]
    assign rx_load      = ren_q & rx_sample & (rx_state_q == UMP_RX_STOP) & rx_accept; // see [R14]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state_q <= UMP_RX_IDLE;
            rx_shift_q <= 8'h00;
            rx_cnt_q   <= 3'h0;
            rx_nine_q  <= 1'b0;
            rx_ninth_q <= 1'b0;
            rx_prev_q  <= 1'b1;
        end else begin
            rx_prev_q <= rxd;
            if (!ren_q) begin
                rx_state_q <= UMP_RX_IDLE;              // see [R07] see [R23]
            end else begin
                unique case (rx_state_q)
                    UMP_RX_IDLE: if (rx_start) begin
                        rx_nine_q  <= mode_q;           // see [R03]
                        rx_state_q <= UMP_RX_START;
                    end
                    UMP_RX_START: if (rx_sample) begin
                        rx_cnt_q   <= 3'h0;
                        // a glitch that is high mid bit is not a start
                        rx_state_q <= rxd ? UMP_RX_IDLE : UMP_RX_DATA;
                    end
                    UMP_RX_DATA: if (rx_sample) begin
                        rx_shift_q <= {rxd, rx_shift_q[7:1]}; // see [R04]
                        rx_cnt_q   <= rx_cnt_q + 3'h1;
                        if (rx_cnt_q == UMP_LAST_DATA) begin
                            rx_state_q <= rx_nine_q ? UMP_RX_NINTH : UMP_RX_STOP;
                        end
                    end
                    UMP_RX_NINTH: if (rx_sample) begin
                        rx_ninth_q <= rxd;              // see [R12]
                        rx_state_q <= UMP_RX_STOP;
                    end
                    UMP_RX_STOP: if (rx_sample) begin
                        rx_state_q <= UMP_RX_IDLE;
                    end
                    default: rx_state_q <= UMP_RX_IDLE;
                endcase
            end
        end
    end

    // receive latch only moves on an accepted character
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_buf_q <= 8'h00;
        end else if (rx_load) begin
            rx_buf_q <= rx_shift_q;                     // see [R08] see [R10]
        end
    end

    // control register; hardware set beats a same-cycle cpu clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= UMP_CTRL_RESET[UMP_BIT_MODE];
            afe_q  <= UMP_CTRL_RESET[UMP_BIT_AFE];
            ren_q  <= UMP_CTRL_RESET[UMP_BIT_REN];
            tb8_q  <= UMP_CTRL_RESET[UMP_BIT_TB8];
            rb8_q  <= UMP_CTRL_RESET[UMP_BIT_RB8];
            ti_q   <= UMP_CTRL_RESET[UMP_BIT_TI];
            ri_q   <= UMP_CTRL_RESET[UMP_BIT_RI];       // see [R20]
        end else begin
            if (ctrl_wr) begin
                mode_q <= cpu_wdata[UMP_BIT_MODE];      // see [R03]
                afe_q  <= cpu_wdata[UMP_BIT_AFE];
                ren_q  <= cpu_wdata[UMP_BIT_REN];       // see [R07]
                tb8_q  <= cpu_wdata[UMP_BIT_TB8];
            end
            if (rx_load) rb8_q <= rx_ninth_val;         // see [R08] see [R12]
            else if (ctrl_wr) rb8_q <= cpu_wdata[UMP_BIT_RB8];
            ti_q <= tx_done_set | (ctrl_wr ? cpu_wdata[UMP_BIT_TI] : ti_q); // see [R16]
            ri_q <= rx_load | (ctrl_wr ? cpu_wdata[UMP_BIT_RI] : ri_q);     // see [R14] see [R16]
        end
    end

    // registered read port; unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_rd) begin
            if (cpu_addr == UMP_CTRL_ADDR) begin
                cpu_rdata <= {mode_q, 1'b1, afe_q, ren_q, tb8_q, rb8_q, ti_q, ri_q}; // see [R20]
            end else if (cpu_addr == UMP_DATA_ADDR) begin
                cpu_rdata <= rx_buf_q;                  // see [R21]
            end else begin
                cpu_rdata <= 8'h00;
            end
        end
    end

    assign irq = int_enable & (ti_q | ri_q);            // see [R15]
endmodule // ump_uart_dev

// ---- src/ump_pkg.sv ----
// Notes on behaviour
// [R01] bit rate is timer clock/(256-reload), halved
// [R02] both overflows halved; start edge reloads rx timer
// [R03] control bit 7 picks 8-bit or 9-bit frames
// [R04] 8-bit frame: start, 8 data lsb first, stop
// [R05] writing data buffer starts a transmission
// [R06] transmit-done set as stop bit begins
// [R07] receiver works only while enable bit 4 set
// [R08] 8-bit mode: stop bit to ninth-receive, gated load
// [R09] rejected character changes no buffer or flag
// [R10] overrun keeps first byte, later ones dropped
// [R11] 9-bit frame adds ninth-transmit bit before stop
// [R12] 9-bit mode: ninth bit stored, filter gates load
// [R13] filter off accepts any ninth bit value
// [R14] receive-done set when stop bit sampled
// [R15] interrupt when either done flag set, if enabled
// [R16] done flags cleared only by cpu writes
// [R17] master sends ninth bit 1 for address only
// [R18] slave software toggles filter around its message
// [R19] ninth-transmit bit unused in 8-bit mode
// [R20] bit 6 reads one; control resets to 0x40
// [R21] data address: write transmits, read gives rx latch
// [R22] tx idles high; rx samples mid bit
// [R23] disabled receiver ignores the line entirely
package ump_pkg;
    localparam logic [7:0] UMP_CTRL_ADDR  = 8'h98;
    localparam logic [7:0] UMP_DATA_ADDR  = 8'h99;
    localparam logic [7:0] UMP_CTRL_RESET = 8'h40;
    localparam int         UMP_BIT_MODE   = 7;
    localparam int         UMP_BIT_ONE    = 6;
    localparam int         UMP_BIT_AFE    = 5;
    localparam int         UMP_BIT_REN    = 4;
    localparam int         UMP_BIT_TB8    = 3;
    localparam int         UMP_BIT_RB8    = 2;
    localparam int         UMP_BIT_TI     = 1;
    localparam int         UMP_BIT_RI     = 0;
    localparam logic [7:0] UMP_TMR_TOP    = 8'hff;
    localparam logic [8:0] UMP_TMR_MOD    = 9'h0100;
    localparam logic [2:0] UMP_LAST_DATA  = 3'h7;
    localparam logic [3:0] UMP_BITS_8     = 4'ha;
    localparam logic [3:0] UMP_BITS_9     = 4'hb;
    localparam int         UMP_FIFO_DEPTH = 4;
endpackage

// ---- src/ump_link_if.sv ----
`timescale 1ns/1ns
// serial pair between the device end and the remote end
interface ump_link_if;
    logic serial_transmit_line;
    logic serial_receive_line;
    modport dev    (output serial_transmit_line, input serial_receive_line);
    modport remote (input serial_transmit_line, output serial_receive_line);
endinterface

// ---- src/ump_fifo.sv ----
`timescale 1ns/1ns
module ump_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_q;
    logic [PW-1:0]    rd_q;
    logic [PW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != PW'(0) + (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rd_q]; // storage is flops, read through a mux on rd_q with no output register

    // storage has no reset; only valid slots are ever read
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + PW'(1);
            if (pop) rd_q <= rd_q + PW'(1);
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // ump_fifo

// ---- src/ump_uart_remote.sv ----
`timescale 1ns/1ns
module ump_uart_remote #(
    parameter int DEPTH = ump_pkg::UMP_FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       nine_bit_mode,
    input  wire logic [7:0] timer_reload_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [8:0] tx_data,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_ninth,
    output logic            rx_frame_err,
    ump_link_if.remote      link
);
    import ump_pkg::*;

    logic        f_valid;
    logic        f_ready;
    logic [8:0]  f_data;
    logic [9:0]  bit_len;
    logic [9:0]  tx_tmr_q;
    logic [10:0] tx_frame_q;
    logic [3:0]  tx_left_q;
    logic        tx_line_q;
    logic [9:0]  rx_tmr_q;
    logic [10:0] rx_frame_q;
    logic [3:0]  rx_left_q;
    logic        rx_prev_q;

    // ninth bit 1 marks an address character; user supplies it
    ump_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    ); // see [R17]

    // one bit is two timer overflows, timer fed by clk
    assign bit_len = {UMP_TMR_MOD[8:0] - {1'b0, timer_reload_byte}, 1'b0}; // see [R01]
    assign f_ready = (tx_left_q == 4'h0);
    assign link.serial_receive_line = tx_line_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_tmr_q   <= 10'h000;
            tx_frame_q <= 11'h7ff;
            tx_left_q  <= 4'h0;
            tx_line_q  <= 1'b1;
        end else if (f_valid && f_ready) begin
            tx_frame_q <= nine_bit_mode ? {1'b1, f_data, 1'b0} : {2'b11, f_data[7:0], 1'b0}; // see [R04] see [R11]
            tx_left_q  <= nine_bit_mode ? UMP_BITS_9 : UMP_BITS_8;
            tx_tmr_q   <= bit_len;
        end else if (tx_left_q != 4'h0) begin
            tx_line_q <= tx_frame_q[0];
            if (tx_tmr_q == 10'h001) begin
                tx_tmr_q   <= bit_len;
                tx_frame_q <= {1'b1, tx_frame_q[10:1]};
                tx_left_q  <= tx_left_q - 4'h1;
            end else begin
                tx_tmr_q <= tx_tmr_q - 10'h001;
            end
        end else begin
            tx_line_q <= 1'b1;
        end
    end

    // receiver: half a bit after the edge, then whole bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_tmr_q     <= 10'h000;
            rx_frame_q   <= 11'h000;
            rx_left_q    <= 4'h0;
            rx_prev_q    <= 1'b1;
            rx_valid     <= 1'b0;
            rx_data      <= 8'h00;
            rx_ninth     <= 1'b0;
            rx_frame_err <= 1'b0;
        end else begin
            rx_prev_q <= link.serial_transmit_line;
            rx_valid  <= 1'b0;
            if (rx_left_q == 4'h0) begin
                if (rx_prev_q && !link.serial_transmit_line) begin
                    rx_left_q <= nine_bit_mode ? UMP_BITS_9 : UMP_BITS_8;
                    rx_tmr_q  <= {1'b0, bit_len[9:1]};
                end
            end else if (rx_tmr_q == 10'h001) begin
                rx_tmr_q   <= bit_len;
                rx_frame_q <= {link.serial_transmit_line, rx_frame_q[10:1]};
                rx_left_q  <= rx_left_q - 4'h1;
                if (rx_left_q == 4'h1) begin
                    rx_valid     <= 1'b1;
                    rx_frame_err <= ~link.serial_transmit_line;
                    if (nine_bit_mode) begin
                        rx_data  <= rx_frame_q[9:2];
                        rx_ninth <= rx_frame_q[10];
                    end else begin
                        rx_data  <= rx_frame_q[10:3];
                        rx_ninth <= 1'b0;
                    end
                end
            end else begin
                rx_tmr_q <= rx_tmr_q - 10'h001;
            end
        end
    end
endmodule // ump_uart_remote

// ---- tb/ump_link_props.sv ----
`timescale 1ns/1ns
// frame tracker for one serial line; a frame opens on a fall seen from idle
module ump_line_mon #(
    parameter int BIT_LEN = 16
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        line,
    output logic             start,
    output logic             busy_q,
    output logic      [11:0] cnt_q,
    output logic      [11:0] gap_q,
    output logic      [11:0] low_q
);
    logic prev_q;

    assign start = !busy_q && prev_q && !line;

    // window closes mid tenth bit slot, clear of any start edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= 1'b1;
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else begin
            prev_q <= line;
            cnt_q  <= start ? 12'h001 : cnt_q + 12'h001;
            if (start)
                busy_q <= 1'b1;
            else if (cnt_q == 12'(9 * BIT_LEN + BIT_LEN / 2))
                busy_q <= 1'b0;
        end
    end

    // distance between starts and length of the current low run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_q <= 12'hfff;
            low_q <= '0;
        end else begin
            gap_q <= start ? 12'h001 : (gap_q == 12'hfff ? gap_q : gap_q + 12'h001);
            low_q <= line ? 12'h000 : low_q + 12'h001;
        end
    end
endmodule // ump_line_mon

module ump_link_props #(
    parameter int BIT_LEN = 16
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic serial_transmit_line,
    input  wire logic serial_receive_line
);
    localparam int FRAME_MIN = 10 * BIT_LEN;
    logic        tx_start;
    logic        tx_busy;
    logic [11:0] tx_cnt;
    logic [11:0] tx_gap;
    logic [11:0] tx_low;
    logic        rx_start;
    logic        rx_busy;
    logic [11:0] rx_cnt;
    logic [11:0] rx_gap;
    logic [11:0] rx_low;

    ump_line_mon #(.BIT_LEN(BIT_LEN)) u_tx_mon (.clk(clk), .rst_b(rst_b), .line(serial_transmit_line),
        .start(tx_start), .busy_q(tx_busy), .cnt_q(tx_cnt), .gap_q(tx_gap), .low_q(tx_low));
    ump_line_mon #(.BIT_LEN(BIT_LEN)) u_rx_mon (.clk(clk), .rst_b(rst_b), .line(serial_receive_line),
        .start(rx_start), .busy_q(rx_busy), .cnt_q(rx_cnt), .gap_q(rx_gap), .low_q(rx_low));

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    idle_after_rst_a: assert property ($rose(rst_b) |-> serial_transmit_line && serial_receive_line)
        else $error("serial line not idle high after reset");
    tx_bit_edge_a: assert property (tx_busy && $changed(serial_transmit_line) |-> tx_cnt % BIT_LEN == 0)
        else $error("transmit edge off a bit boundary");
    rx_bit_edge_a: assert property (rx_busy && $changed(serial_receive_line) |-> rx_cnt % BIT_LEN == 0)
        else $error("receive line edge off a bit boundary");
    // two runs of eight cover a 16-cycle start bit
    tx_start_low_a: assert property (tx_start |-> (!serial_transmit_line) [*8] ##1 (!serial_transmit_line) [*8])
        else $error("transmit start bit too short");
    rx_start_low_a: assert property (rx_start |-> (!serial_receive_line) [*8] ##1 (!serial_receive_line) [*8])
        else $error("receive line start bit too short");
    tx_frame_gap_a: assert property (tx_start |-> tx_gap >= FRAME_MIN)
        else $error("transmit frames closer than ten bits");
    rx_frame_gap_a: assert property (rx_start |-> rx_gap >= FRAME_MIN)
        else $error("receive line frames closer than ten bits");
    tx_stop_seen_a: assert property (!serial_transmit_line |-> tx_low < FRAME_MIN)
        else $error("transmit line low past a whole frame");

    cover property (tx_start);
    cover property (rx_start);
    cover property (tx_busy && tx_cnt == 12'(9 * BIT_LEN) && serial_transmit_line);
endmodule // ump_link_props

// ---- tb/tb.sv ----
`timescale 1ns/1ns
module tb;
    import ump_pkg::*;
    localparam logic [7:0] RELOAD  = 8'hf8; // 16-cycle bits keep frames short
    localparam int         BIT_LEN = 16;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       cpu_wr = 1'b0;
    logic       cpu_rd = 1'b0;
    logic [7:0] cpu_addr = 8'h00;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] cpu_rdata;
    logic       int_enable = 1'b1;
    logic       irq;
    logic       nine = 1'b0;
    logic       tx_valid = 1'b0;
    logic       tx_ready;
    logic [8:0] tx_data = 9'h000;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       rx_ninth;
    logic       rx_frame_err;
    int         n_errors = 0;
    int         checked = 0;

    always #10 clk = ~clk;

    ump_link_if link_i ();
    ump_uart_dev u_ump_uart_dev (.clk(clk), .rst_b(rst_b), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .int_enable(int_enable), .timer_reload_byte(RELOAD),
        .timer_tick(1'b1), .irq(irq), .link(link_i));
    ump_uart_remote u_ump_uart_remote (.clk(clk), .rst_b(rst_b), .nine_bit_mode(nine), .timer_reload_byte(RELOAD),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ninth(rx_ninth), .rx_frame_err(rx_frame_err), .link(link_i));
    ump_link_props #(.BIT_LEN(BIT_LEN)) u_ump_link_props (.clk(clk), .rst_b(rst_b),
        .serial_transmit_line(link_i.serial_transmit_line), .serial_receive_line(link_i.serial_receive_line));

    task automatic end_of_test();
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cpu_wr    <= 1'b1;
        cpu_addr  <= a;
        cpu_wdata <= d;
        @(posedge clk);
        cpu_wr <= 1'b0;
    endtask

    // rdata holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cpu_rd   <= 1'b1;
        cpu_addr <= a;
        @(posedge clk);
        cpu_rd <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        d = cpu_rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({1'b0, d}, {1'b0, exp});
    endtask

    // poll control until a character lands, bounded
    task automatic wait_ri();
        logic [7:0] d;
        for (int i = 0; i < 100; i++) begin
            rd(UMP_CTRL_ADDR, d);
            if (d[UMP_BIT_RI] === 1'b1)
                break;
        end
    endtask

    task automatic wait_remote(input logic [7:0] exp);
        for (int i = 0; i < 600 && rx_valid !== 1'b1; i++)
            @(negedge clk);
        chk({1'b0, rx_data}, {1'b0, exp});
        chk({8'h00, rx_frame_err}, 9'h000);
        repeat (BIT_LEN) @(negedge clk);
    endtask

    task automatic push(input logic [8:0] v);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data  <= v;
        @(negedge clk);
        while (tx_ready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    // whole run is near 3400 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        int i;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        // reset value, stuck bit 6, unmapped read
        chk_rd(UMP_CTRL_ADDR, UMP_CTRL_RESET);
        wr(UMP_CTRL_ADDR, 8'h00);
        chk_rd(UMP_CTRL_ADDR, 8'h40);
        chk_rd(8'h12, 8'h00);
        // 8-bit transmit, done flag stays, interrupt follows flag and enable
        wr(UMP_DATA_ADDR, 8'ha5);
        wait_remote(8'ha5);
        repeat (50) @(posedge clk);
        chk_rd(UMP_CTRL_ADDR, 8'h42);
        chk({8'h00, irq}, 9'h001);
        @(posedge clk);
        int_enable <= 1'b0;
        @(negedge clk);
        chk({8'h00, irq}, 9'h000);
        int_enable <= 1'b1;
        wr(UMP_CTRL_ADDR, 8'h00);
        chk_rd(UMP_CTRL_ADDR, 8'h40);
        // ninth bit sent only in 9-bit mode
        nine <= 1'b1;
        wr(UMP_CTRL_ADDR, 8'h88);
        wr(UMP_DATA_ADDR, 8'h3c);
        wait_remote(8'h3c);
        chk({8'h00, rx_ninth}, 9'h001);
        nine <= 1'b0;
        wr(UMP_CTRL_ADDR, 8'h08);
        wr(UMP_DATA_ADDR, 8'hc3);
        wait_remote(8'hc3);
        // 8-bit receive, then an overrun that must be dropped
        wr(UMP_CTRL_ADDR, 8'h10);
        push(9'h05a);
        wait_ri();
        chk_rd(UMP_CTRL_ADDR, 8'h55);
        chk_rd(UMP_DATA_ADDR, 8'h5a);
        push(9'h077);
        repeat (250) @(posedge clk);
        chk_rd(UMP_DATA_ADDR, 8'h5a);
        chk_rd(UMP_CTRL_ADDR, 8'h55);
        // receiver off: fill the far fifo, all ignored
        wr(UMP_CTRL_ADDR, 8'h00);
        for (i = 0; i < 8; i++) begin
            @(negedge clk);
            if (tx_ready !== 1'b1)
                break;
            push(9'h011 + 9'(i));
        end
        chk({8'h00, i >= UMP_FIFO_DEPTH}, 9'h001);
        chk({8'h00, tx_ready}, 9'h000);
        repeat (1600) @(posedge clk);
        chk({8'h00, tx_ready}, 9'h001);
        chk_rd(UMP_CTRL_ADDR, 8'h40);
        chk_rd(UMP_DATA_ADDR, 8'h5a);
        // 9-bit filter: data refused, address taken, then all
        nine <= 1'b1;
        wr(UMP_CTRL_ADDR, 8'hb0);
        push(9'h022);
        repeat (250) @(posedge clk);
        chk_rd(UMP_CTRL_ADDR, 8'hf0);
        push(9'h133);
        wait_ri();
        chk_rd(UMP_CTRL_ADDR, 8'hf5);
        chk_rd(UMP_DATA_ADDR, 8'h33);
        wr(UMP_CTRL_ADDR, 8'h90);
        push(9'h044);
        wait_ri();
        chk_rd(UMP_CTRL_ADDR, 8'hd1);
        chk_rd(UMP_DATA_ADDR, 8'h44);
        end_of_test();
    end
endmodule // tb
